// ===== qec_pkg.sv
// package of register map, field layout and timing constants for the encoder counter block
package qec_pkg;
	localparam int          NUM_CH            = 4;
	// register byte offsets
	localparam logic [7:0]  OFS_MODE0         = 8'h00;  // mode registers at 00,04,08,0C
	localparam logic [7:0]  OFS_DATA0         = 8'h10;  // latched counter reads at 10,14,18,1C
	localparam logic [7:0]  OFS_INT_ENABLE    = 8'h20;
	localparam logic [7:0]  OFS_CLOCK_CLEAR   = 8'h24;  // write: clock control, read: clear interrupt
	localparam logic [7:0]  OFS_SOFT_CAPTURE  = 8'h28;
	localparam logic [7:0]  OFS_COUNTER_RESET = 8'h2C;
	localparam logic [7:0]  OFS_INT_STATUS    = 8'h34;
	localparam logic [7:0]  OFS_COMPARE0      = 8'h40;  // compare values at 40,44,48,4C
	// mode register fields
	localparam int          MODE_LSB          = 0;
	localparam int          RVS_BIT           = 4;      // reset_value_select
	localparam int          LSRC_LSB          = 8;
	localparam logic [31:0] MODE_MASK         = 32'h0000_0717;
	localparam logic [31:0] RESET_VALUE_LOW   = 32'h8000_0000;
	localparam logic [31:0] RESET_VALUE_HIGH  = 32'h0000_0000;
	// clock control fields
	localparam int          RATE_LSB          = 0;
	localparam int          DIV_LSB           = 16;
	localparam int          BASE_LSB          = 24;
	// interrupt enable / status layout
	localparam int          IRQ_OVF_LSB       = 0;
	localparam int          IRQ_UNF_LSB       = 4;
	localparam int          IRQ_IDX_LSB       = 8;
	localparam int          IRQ_DI_LSB        = 12;
	localparam int          IRQ_OVC_LSB       = 16;
	localparam int          IRQ_UNC_LSB       = 20;
	localparam int          IRQ_TMR_BIT       = 24;
	localparam int          IRQ_ALL_BIT       = 31;
	localparam int          IRQ_SRC_W         = 25;
	// filter
	localparam int          FILTER_DEPTH      = 4;
	localparam logic [3:0]  SYS_RATE_MHZ      = 4'hA;   // pclk in MHz, sample tick accumulator modulus
	// timing
	localparam int          CLK_PERIOD_NS     = 100;
	localparam int          BASE_50K_NS       = 20000;
	localparam int          BASE_5K_NS        = 200000;
	localparam int          BASE_500_NS       = 2000000;
	localparam int          BASE_50_NS        = 20000000;
	localparam int          BASE_5_NS         = 200000000;
	localparam int          BASE_50K_CYCLES   = BASE_50K_NS / CLK_PERIOD_NS;
	localparam int          BASE_5K_CYCLES    = BASE_5K_NS / CLK_PERIOD_NS;
	localparam int          BASE_500_CYCLES   = BASE_500_NS / CLK_PERIOD_NS;
	localparam int          BASE_50_CYCLES    = BASE_50_NS / CLK_PERIOD_NS;
	localparam int          BASE_5_CYCLES     = BASE_5_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		QEC_DISABLED, QEC_QUAD_X1, QEC_QUAD_X2, QEC_QUAD_X4, QEC_TWO_PULSE, QEC_PULSE_DIR
	} qec_mode_type;

	typedef enum logic [2:0] {
		QEC_LATCH_SOFT, QEC_LATCH_INDEX, QEC_LATCH_GI0, QEC_LATCH_GI1, QEC_LATCH_GI2, QEC_LATCH_GI3,
		QEC_LATCH_TIMER
	} qec_latch_type;
endpackage : qec_pkg

// ===== qec_counter.sv
// four-channel incremental encoder counter with filter, latch, timer and interrupt logic on apb
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// (RQ1) x1: count on filtered A rising only
// (RQ2) x2: count on both edges of A
// (RQ3) x4: count on every A and B edge
// (RQ4) A leading B counts up, else down
// (RQ5) two-pulse: A rise up, B rise down
// (RQ6) pulse/direction: A rise, B high counts down
// (RQ7) disabled mode ignores inputs, registers stay accessible
// (RQ8) per-channel mode register at successive words
// (RQ9) filter passes level held four samples
// (RQ10) sample rate selectable 1, 2, 4, 8 MHz
// (RQ11) rate field: 00=8,01=4,10=2,11=1 MHz
// (RQ12) reads return latch, one of seven sources
// (RQ13) soft mode: data read captures counter
// (RQ14) soft capture command bit copies counter
// (RQ15) index rising edge captures counter
// (RQ16) general input rising edge captures counter
// (RQ17) timer pulse captures counter
// (RQ18) select bit four: 0 gives 80000000h, 1 zero
// (RQ19) 32-bit wrapping counter flags over/underflow
// (RQ20) timer period from 20 us to 51 s
// (RQ21) base select decades and eight-bit divider
// (RQ22) interrupt sources per counter, input, timer
// (RQ23) interrupt only for enabled sources
// (RQ24) reading clear register clears pending interrupt
// (RQ25) reset command loads reset value next sample
module qec_counter #(
	parameter int BASE_5K_COUNT   = qec_pkg::BASE_5K_CYCLES,   // cycles of the 5 kHz time base
	parameter int BASE_500_COUNT  = qec_pkg::BASE_500_CYCLES,  // cycles of the 500 Hz time base
	parameter int BASE_50_COUNT   = qec_pkg::BASE_50_CYCLES,   // cycles of the 50 Hz time base
	parameter int BASE_5_COUNT    = qec_pkg::BASE_5_CYCLES     // cycles of the 5 Hz time base
) (
	input  wire logic        pclk,              // bus and core clock, 10 MHz
	input  wire logic        presetn,           // asynchronous reset, active low
	input  wire logic        clk_en,            // freezes all state while low
	input  wire logic        psel,              // apb select
	input  wire logic        penable,           // apb access phase
	input  wire logic        pwrite,            // apb direction
	input  wire logic [7:0]  paddr,             // apb byte address
	input  wire logic [31:0] pwdata,            // apb write data
	output logic      [31:0] prdata,            // apb read data, registered
	output logic             pready,            // apb ready, registered
	output logic             pslverr,           // apb error on unmapped address
	input  wire logic [3:0]  enc_a,             // encoder A pins, asynchronous
	input  wire logic [3:0]  enc_b,             // encoder B pins, asynchronous
	input  wire logic [3:0]  enc_index,         // encoder index pins, asynchronous
	input  wire logic [3:0]  general_input,     // board general inputs, asynchronous
	output logic             irq                // interrupt request, active high level
);
	import qec_pkg::*;

	localparam int PRE_W = 32;

	// per-channel registers, then shared interrupt, clock and reset state
	logic [31:0] mode_reg [NUM_CH];
	logic [31:0] count [NUM_CH];
	logic [31:0] latch_buf [NUM_CH];
	logic [31:0] compare [NUM_CH];
	logic [31:0] int_enable;
	logic [1:0]  filter_sample_rate_select;
	logic [2:0]  timer_base_select;
	logic [7:0]  timer_divider;
	logic [IRQ_SRC_W-1:0] pending;
	logic [3:0]  reset_req;

	// step decode: returns {up, down} for one channel
	function automatic logic [1:0] step_of(input logic [2:0] mode, input logic a, input logic b,
			input logic pa, input logic pb);
		logic up;
		logic a_rise;
		logic a_chg;
		logic b_chg;
		up     = a ^ pb;                     // A leading B gives up RQ4
		a_rise = a & ~pa;
		a_chg  = a ^ pa;
		b_chg  = b ^ pb;
		step_of = 2'b00;
		unique case (mode)
			QEC_QUAD_X1:   step_of = a_rise ? {up, ~up} : 2'b00;                     // RQ1
			QEC_QUAD_X2:   step_of = a_chg ? {up, ~up} : 2'b00;                      // RQ2
			QEC_QUAD_X4:   step_of = (a_chg ^ b_chg) ? {up, ~up} : 2'b00;            // RQ3
			QEC_TWO_PULSE: step_of = {a_rise & ~(b & ~pb), (b & ~pb) & ~a_rise};     // RQ5
			QEC_PULSE_DIR: step_of = a_rise ? {~b, b} : 2'b00;                       // RQ6
			default:       step_of = 2'b00;                                          // RQ7
		endcase
	endfunction : step_of

	// apb access decode
	logic       rd_fire;
	logic       wr_fire;
	logic [5:0] word;
	logic       is_data;
	logic       is_mode;
	logic       is_cmp;
	logic [1:0] sel_ch;
	assign word    = paddr[7:2];
	assign sel_ch  = paddr[3:2];
	assign is_mode = (paddr[7:4] == OFS_MODE0[7:4]) && (paddr[1:0] == 2'b00);
	assign is_data = (paddr[7:4] == OFS_DATA0[7:4]) && (paddr[1:0] == 2'b00);
	assign is_cmp  = (paddr[7:4] == OFS_COMPARE0[7:4]) && (paddr[1:0] == 2'b00);
	assign rd_fire = psel & penable & ~pwrite & ~pready & clk_en;
	assign wr_fire = psel & penable & pwrite & pready & clk_en;

	// pin synchronisers: first stage feeds only the second
	logic [15:0] pin_meta;
	logic [15:0] pin_sync;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 16'h0000;
			pin_sync <= 16'h0000;
		end else if (clk_en) begin
			pin_meta <= {general_input, enc_index, enc_b, enc_a};
			pin_sync <= pin_meta;
		end
	end

	// sample tick: fractional accumulator, average rate exact though ticks jitter by one pclk
	logic [3:0] rate_mhz;
	logic [3:0] acc;
	logic [4:0] acc_sum;
	logic       tick;
	always_comb begin
		unique case (filter_sample_rate_select)                 // RQ11
			2'b00:   rate_mhz = 4'h8;
			2'b01:   rate_mhz = 4'h4;
			2'b10:   rate_mhz = 4'h2;
			default: rate_mhz = 4'h1;
		endcase
	end
	assign acc_sum = {1'b0, acc} + {1'b0, rate_mhz};
	assign tick    = (acc_sum >= {1'b0, SYS_RATE_MHZ});
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 4'h0;
		end else if (clk_en) begin
			acc <= tick ? 4'(acc_sum - {1'b0, SYS_RATE_MHZ}) : acc_sum[3:0];  // RQ10
		end
	end

	// four-sample glitch filter on every input
	logic [FILTER_DEPTH-1:0] hist [16];
	logic [15:0]             filt;
	logic [15:0]             filt_prev;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) begin
				hist[i] <= '0;
			end
			filt      <= 16'h0000;
			filt_prev <= 16'h0000;
		end else if (clk_en) begin
			filt_prev <= filt;
			if (tick) begin
				for (int i = 0; i < 16; i++) begin
					hist[i] <= {hist[i][FILTER_DEPTH-2:0], pin_sync[i]};
					if (&hist[i]) begin
						filt[i] <= 1'b1;                         // RQ9
					end else if (~|hist[i]) begin
						filt[i] <= 1'b0;                         // RQ9
					end
				end
			end
		end
	end

	// filtered edges and count steps
	logic [3:0] up;
	logic [3:0] dn;
	logic [3:0] idx_rise;
	logic [3:0] gi_rise;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			{up[c], dn[c]} = step_of(mode_reg[c][MODE_LSB +: 3], filt[c], filt[4+c], filt_prev[c],
				filt_prev[4+c]);
		end
		idx_rise = filt[11:8] & ~filt_prev[11:8];
		gi_rise  = filt[15:12] & ~filt_prev[15:12];
	end

	// interval timer: decade base then eight-bit divider, divider 0 stops it
	logic [PRE_W-1:0] base_len;
	logic [PRE_W-1:0] pre_cnt;
	logic [7:0]       div_cnt;
	logic             base_tick;
	logic             timer_pulse;
	always_comb begin
		unique case (timer_base_select)                        // RQ21
			3'b000:  base_len = PRE_W'(BASE_50K_CYCLES);
			3'b001:  base_len = PRE_W'(BASE_5K_COUNT);
			3'b010:  base_len = PRE_W'(BASE_500_COUNT);
			3'b011:  base_len = PRE_W'(BASE_50_COUNT);
			3'b100:  base_len = PRE_W'(BASE_5_COUNT);
			default: base_len = '0;
		endcase
	end
	assign base_tick   = (base_len != '0) && (timer_divider != 8'h00) && (pre_cnt >= base_len - 1'b1);
	assign timer_pulse = base_tick && (div_cnt >= timer_divider - 8'h01);   // RQ20
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_cnt <= '0;
			div_cnt <= 8'h00;
		end else if (clk_en) begin
			if (base_len == '0 || timer_divider == 8'h00) begin
				pre_cnt <= '0;
				div_cnt <= 8'h00;
			end else if (base_tick) begin
				pre_cnt <= '0;
				div_cnt <= timer_pulse ? 8'h00 : div_cnt + 8'h01;
			end else begin
				pre_cnt <= pre_cnt + 1'b1;
			end
		end
	end

	// counters: reset command waits for the next sample tick
	logic [3:0] ovf;
	logic [3:0] unf;
	logic [3:0] ovc;
	logic [3:0] unc;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				count[c] <= RESET_VALUE_LOW;
			end
			reset_req <= 4'h0;
		end else if (clk_en) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (reset_req[c] && tick) begin
					count[c] <= mode_reg[c][RVS_BIT] ? RESET_VALUE_HIGH : RESET_VALUE_LOW;  // RQ18 RQ25
				end else if (up[c]) begin
					count[c] <= count[c] + 32'h0000_0001;           // RQ19
				end else if (dn[c]) begin
					count[c] <= count[c] - 32'h0000_0001;           // RQ19
				end
				if (wr_fire && word == OFS_COUNTER_RESET[7:2] && pwdata[c]) begin
					reset_req[c] <= 1'b1;
				end else if (tick) begin
					reset_req[c] <= 1'b0;
				end
			end
		end
	end

	// counter events for the interrupt sources
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			ovf[c] = up[c] && !(reset_req[c] && tick) && (count[c] == 32'hFFFF_FFFF);  // RQ19
			unf[c] = dn[c] && !(reset_req[c] && tick) && (count[c] == 32'h0000_0000);  // RQ19
			ovc[c] = up[c] && (count[c] + 32'h0000_0001 == compare[c]);
			unc[c] = dn[c] && (count[c] - 32'h0000_0001 == compare[c]);
		end
	end

	// latch buffers: one selected source per channel, none when disabled, plus the soft capture command
	logic [3:0] cap;
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			cap[c] = 1'b0;
			if (mode_reg[c][MODE_LSB +: 3] != QEC_DISABLED) begin
				unique case (mode_reg[c][LSRC_LSB +: 3])                     // RQ12
					QEC_LATCH_SOFT:  cap[c] = rd_fire && is_data && sel_ch == 2'(c);  // RQ13
					QEC_LATCH_INDEX: cap[c] = idx_rise[c];                   // RQ15
					QEC_LATCH_GI0:   cap[c] = gi_rise[0];                    // RQ16
					QEC_LATCH_GI1:   cap[c] = gi_rise[1];                    // RQ16
					QEC_LATCH_GI2:   cap[c] = gi_rise[2];                    // RQ16
					QEC_LATCH_GI3:   cap[c] = gi_rise[3];                    // RQ16
					QEC_LATCH_TIMER: cap[c] = timer_pulse;                   // RQ17
					default:         cap[c] = 1'b0;
				endcase
			end
			if (wr_fire && word == OFS_SOFT_CAPTURE[7:2] && pwdata[c]) begin
				cap[c] = 1'b1;                                               // RQ14
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				latch_buf[c] <= 32'h0000_0000;
			end
		end else if (clk_en) begin
			for (int c = 0; c < NUM_CH; c++) begin
				if (cap[c]) begin
					latch_buf[c] <= count[c];
				end
			end
		end
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int c = 0; c < NUM_CH; c++) begin
				mode_reg[c] <= 32'h0000_0000;
				compare[c]  <= 32'h0000_0000;
			end
			int_enable                <= 32'h0000_0000;
			filter_sample_rate_select <= 2'b00;
			timer_base_select         <= 3'b000;
			timer_divider             <= 8'h00;
		end else if (wr_fire) begin
			if (is_mode) begin
				mode_reg[sel_ch] <= pwdata & MODE_MASK;                      // RQ8
			end
			if (is_cmp) begin
				compare[sel_ch] <= pwdata;
			end
			if (word == OFS_INT_ENABLE[7:2]) begin
				int_enable <= pwdata;                                        // RQ23
			end
			if (word == OFS_CLOCK_CLEAR[7:2]) begin
				filter_sample_rate_select <= pwdata[RATE_LSB +: 2];
				timer_base_select         <= pwdata[BASE_LSB +: 3];
				timer_divider             <= pwdata[DIV_LSB +: 8];
			end
		end
	end

	// pending sources: a new event in the clearing read's cycle survives
	logic [IRQ_SRC_W-1:0] events;
	logic                 clear_rd;
	assign events = {timer_pulse, unc, ovc, gi_rise, idx_rise & filt_en(mode_reg), unf, ovf};  // RQ22
	assign clear_rd = rd_fire && word == OFS_CLOCK_CLEAR[7:2];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= '0;
		end else if (clk_en) begin
			pending <= (clear_rd ? '0 : pending) | events;                     // RQ24
		end
	end

	// channels not disabled, so a disabled channel raises no index event
	function automatic logic [3:0] filt_en(input logic [31:0] m [NUM_CH]);
		for (int c = 0; c < NUM_CH; c++) begin
			filt_en[c] = (m[c][MODE_LSB +: 3] != QEC_DISABLED);
		end
	endfunction : filt_en

	// interrupt line from enabled pending sources
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= int_enable[IRQ_ALL_BIT] && |(pending & int_enable[IRQ_SRC_W-1:0]);  // RQ23
		end
	end

	// read mux; a soft-mode data read returns the value being captured
	logic [31:0] rd_val;
	logic        rd_err;
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_err = 1'b0;
		if (is_mode) begin
			rd_val = mode_reg[sel_ch];
		end else if (is_data) begin
			rd_val = cap[sel_ch] ? count[sel_ch] : latch_buf[sel_ch];  // RQ12
		end else if (is_cmp) begin
			rd_val = compare[sel_ch];
		end else if (word == OFS_INT_ENABLE[7:2]) begin
			rd_val = int_enable;
		end else if (word == OFS_INT_STATUS[7:2]) begin
			rd_val = 32'(pending);
		end else if (word != OFS_CLOCK_CLEAR[7:2]) begin
			rd_err = 1'b1;
		end
	end

	// apb response: one wait state, every transfer completes in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			if (psel && penable && !pready) begin
				pready  <= 1'b1;
				prdata  <= pwrite ? 32'h0000_0000 : rd_val;
				pslverr <= pwrite ? !(is_mode || is_cmp || word == OFS_INT_ENABLE[7:2]
					|| word == OFS_CLOCK_CLEAR[7:2] || word == OFS_SOFT_CAPTURE[7:2]
					|| word == OFS_COUNTER_RESET[7:2]) : rd_err;
			end else begin
				pready  <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end
endmodule : qec_counter

`default_nettype wire

// ===== qec_monitor.sv
// assertion checker on the apb port and interrupt line of the encoder counter
`timescale 1ns/100ps
`default_nettype none
module qec_monitor
	import qec_pkg::*;
(
	input wire logic        pclk,          // clock
	input wire logic        presetn,       // reset, low
	input wire logic        clk_en,        // enable
	input wire logic        psel,          // select
	input wire logic        penable,       // access
	input wire logic        pwrite,        // direction
	input wire logic [7:0]  paddr,         // address
	input wire logic [31:0] pwdata,        // write data
	input wire logic [31:0] prdata,        // read data
	input wire logic        pready,        // ready
	input wire logic        pslverr,       // error
	input wire logic [3:0]  enc_a,         // A pins
	input wire logic [3:0]  enc_b,         // B pins
	input wire logic [3:0]  enc_index,     // index pins
	input wire logic [3:0]  general_input, // inputs
	input wire logic        irq            // interrupt
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic done = psel && penable && pready;
	wire logic clr  = done && !pwrite && (paddr == OFS_CLOCK_CLEAR);
	logic [31:0] mode_sh [4];
	logic [31:0] en_sh;
	// gaps error; writes to read-only data/status and reads of write-only commands error too
	function automatic logic bad(input logic [7:0] a, input logic w);
		return a == 8'h30 || a[7:3] == 5'h07 || a > 8'h4C || (w ? a[7:4] == 4'h1 || a == 8'h34 : a[7:3] == 5'h05);
	endfunction : bad
	// shadow of software writes, so readback is judged from the ports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_sh <= '{default: '0};
			en_sh   <= '0;
		end else if (done && pwrite && !pslverr) begin
			if (paddr[7:4] == 4'h0) mode_sh[paddr[3:2]] <= pwdata & MODE_MASK;
			if (paddr == OFS_INT_ENABLE) en_sh <= pwdata & 32'h81FF_FFFF;
		end
	end
	mode_readback_a: assert property (done && !pwrite && paddr[7:4] == 4'h0 |-> prdata == mode_sh[paddr[3:2]])
		else $error("mode readback differs");
	enable_readback_a: assert property (done && !pwrite && paddr == OFS_INT_ENABLE |-> prdata == en_sh)
		else $error("enable readback differs");
	irq_needs_enable_a: assert property ($rose(irq) |-> en_sh[31] && en_sh[24:0] != 25'h0)
		else $error("irq with no source enabled");
	clear_drops_irq_a: assert property (clr |-> ##[0:2] !irq)
		else $error("clear read left irq high");
	clear_reads_zero_a: assert property (clr |-> prdata == 32'h0000_0000)
		else $error("clear read returned nonzero");
	ready_one_cycle_a: assert property (pready |=> !pready)
		else $error("ready held over one cycle");
	ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not after one wait state");
	error_decode_a: assert property (done |-> pslverr == bad(paddr, pwrite))
		else $error("wrong error response");
	reset_quiet_a: assert property ($rose(presetn) |-> !irq && !pready)
		else $error("outputs active after reset");
	cover property (done && pslverr);
	cover property ($rose(irq));
	cover property (clr);
endmodule : qec_monitor
bind qec_counter qec_monitor qec_monitor_inst (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .enc_a, .enc_b, .enc_index, .general_input, .irq);
`default_nettype wire

// ===== qec_encoder_model.sv
// behavioural encoder and pulse source driving the counter pins
`timescale 1ns/100ps
`default_nettype none
module qec_encoder_model (
	input wire logic       pclk,         // clock
	input wire logic       presetn,      // reset, low
	input wire logic       start,        // begin a burst
	input wire logic [2:0] kind,         // 0 fwd,1 rev,2 A,3 B,4 index,5 input,6 set B
	input wire logic [1:0] ch,           // channel or input line
	input wire logic [7:0] steps,        // phases or pulses, B level for 6
	input wire logic [7:0] hold,         // extra cycles a level stays
	output logic           busy,         // burst running
	output logic     [3:0] enc_a,        // A pins
	output logic     [3:0] enc_b,        // B pins
	output logic     [3:0] enc_index,    // index pins
	output logic     [3:0] general_input // input pins
);
	logic [2:0] k;
	logic [1:0] c;
	logic [7:0] h;
	logic       lvl;
	logic [8:0] left;
	logic [7:0] tmr;
	// one edge per step; forward keeps A a quarter cycle ahead of B, pulses end at the level they started from
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{busy, k, c, h, lvl, left, tmr} <= '0;
			{enc_a, enc_b, enc_index, general_input} <= '0;
		end else if (start && !busy) begin
			busy <= 1'b1;
			{k, c, h, lvl, tmr} <= {kind, ch, hold, steps[0], 8'h00};
			left <= (kind < 3'h2) ? {1'b0, steps} : (kind == 3'h6) ? 9'h001 : {steps, 1'b0};
		end else if (busy) begin
			if (tmr != 8'h00) tmr <= tmr - 8'h01;
			else if (left == 9'h000) busy <= 1'b0;
			else begin
				left <= left - 9'h001;
				tmr <= h;
				case (k)
					3'h0: begin
						enc_a[c] <= ~enc_b[c];
						enc_b[c] <= enc_a[c];
					end
					3'h1: begin
						enc_a[c] <= enc_b[c];
						enc_b[c] <= ~enc_a[c];
					end
					3'h2: enc_a[c] <= ~enc_a[c];
					3'h3: enc_b[c] <= ~enc_b[c];
					3'h4: enc_index[c] <= ~enc_index[c];
					3'h5: general_input[c] <= ~general_input[c];
					default: enc_b[c] <= lvl;
				endcase
			end
		end
	end
endmodule : qec_encoder_model
`default_nettype wire

// ===== tb_quad_encoder_counter_channel.sv
// self-checking bench for the encoder counter through its apb port
`timescale 1ns/100ps
`default_nettype none
module tb_quad_encoder_counter_channel;
	import qec_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
	logic [7:0]  paddr = 8'h00, steps = 8'h00, hold = 8'h13;
	logic [31:0] pwdata = 32'h0, prdata, rd_val;
	logic [2:0]  kind = 3'h0;
	logic [1:0]  ch = 2'h0, c;
	logic        pready, pslverr, irq, busy, err_val;
	logic [3:0]  enc_a, enc_b, enc_index, general_input;
	int          n_errors = 0, compares = 0;
	qec_mode_type mtab [6] = '{QEC_QUAD_X1, QEC_QUAD_X2, QEC_QUAD_X4, QEC_TWO_PULSE, QEC_PULSE_DIR, QEC_DISABLED};
	logic [31:0]  etab [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFE, 32'hFFFF_FFFC, 32'hFFFF_FFFE, 32'hFFFF_FFFE, 32'h0};
	always #50 pclk = ~pclk;
	// small time bases keep timer runs short
	qec_counter #(.BASE_5K_COUNT(20), .BASE_500_COUNT(40), .BASE_50_COUNT(80), .BASE_5_COUNT(160)) qec_counter_inst (
		.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.enc_a, .enc_b, .enc_index, .general_input, .irq);
	qec_encoder_model qec_encoder_model_inst (.pclk, .presetn, .start, .kind, .ch, .steps, .hold, .busy, .enc_a,
		.enc_b, .enc_index, .general_input);
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one apb transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) chk("pready", 32'h1, 32'h0);
		rd_val = prdata;
		err_val = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk("write error", 32'h0, 32'(err_val));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, exp, rd_val);
	endtask : rd
	// encoder burst, then wait out sync and filter latency
	task automatic enc(input logic [2:0] k, input logic [1:0] n_ch, input logic [7:0] n, h = 8'h13);
		int i;
		@(posedge pclk);
		{kind, ch, steps, hold, start} <= {k, n_ch, n, h, 1'b1};
		@(posedge pclk);
		start <= 1'b0;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (busy === 1'b1 && i < 8000);
		repeat (60) @(posedge pclk);
	endtask : enc
	task automatic rst_ch(input logic [1:0] n_ch);
		wr(OFS_COUNTER_RESET, 32'h1 << n_ch);
		repeat (5) @(posedge pclk);
	endtask : rst_ch
	task automatic stop_test();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial begin
		repeat (60000) @(posedge pclk);
		n_errors++;
		stop_test();
	end
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			rd(OFS_MODE0 + 8'(4 * i), 32'h0, "mode reset");
			wr(OFS_MODE0 + 8'(4 * i), 32'hFFFF_FFFF);
			rd(OFS_MODE0 + 8'(4 * i), MODE_MASK, "mode bits");
		end
		rd(OFS_INT_ENABLE, 32'h0, "enable reset");
		rd(OFS_DATA0, 32'h0, "latch reset");
		apb(1'b0, 8'h3C, 32'h0);
		chk("unmapped error", 32'h1, 32'(err_val));
		$display("test registers done");
		// every counting mode, then the other reset value
		for (int m = 0; m < 6; m++) begin
			c = 2'(m);
			wr(OFS_MODE0 + 8'(4 * c), 32'h10 | 32'(mtab[m]));
			rst_ch(c);
			if (mtab[m] == QEC_TWO_PULSE) begin
				enc(3'h2, c, 8'h03);
				enc(3'h3, c, 8'h05);
			end else if (mtab[m] == QEC_PULSE_DIR) begin
				enc(3'h2, c, 8'h03);
				enc(3'h6, c, 8'h01);
				enc(3'h2, c, 8'h05);
				enc(3'h6, c, 8'h00);
			end else begin
				enc(3'h0, c, 8'h08);
				enc(3'h1, c, 8'h0C);
			end
			wr(OFS_SOFT_CAPTURE, 32'h1 << c);
			rd(OFS_DATA0 + 8'(4 * c), etab[m], "mode count");
			wr(OFS_MODE0 + 8'(4 * c), 32'(mtab[m]));
			rst_ch(c);
			wr(OFS_SOFT_CAPTURE, 32'h1 << c);
			rd(OFS_DATA0 + 8'(4 * c), RESET_VALUE_LOW, "reset value");
		end
		$display("test modes done");
		wr(OFS_MODE0, 32'h13);
		rst_ch(2'h0);
		enc(3'h0, 2'h0, 8'h04);
		rd(OFS_DATA0, 32'h4, "soft read");
		wr(OFS_MODE0, 32'h113);
		enc(3'h0, 2'h0, 8'h04);
		rd(OFS_DATA0, 32'h4, "held latch");
		enc(3'h4, 2'h0, 8'h01);
		enc(3'h0, 2'h0, 8'h02);
		rd(OFS_DATA0, 32'h8, "index latch");
		wr(OFS_SOFT_CAPTURE, 32'h0);
		rd(OFS_DATA0, 32'h8, "capture zero");
		wr(OFS_SOFT_CAPTURE, 32'h1);
		rd(OFS_DATA0, 32'hA, "capture one");
		wr(OFS_MODE0, 32'h313);
		enc(3'h0, 2'h0, 8'h02);
		enc(3'h5, 2'h2, 8'h01);
		rd(OFS_DATA0, 32'hA, "other input");
		enc(3'h5, 2'h1, 8'h01);
		rd(OFS_DATA0, 32'hC, "input latch");
		wr(OFS_MODE0, 32'h613);
		enc(3'h0, 2'h0, 8'h02);
		wr(OFS_CLOCK_CLEAR, 32'h0001_0000);
		wr(OFS_INT_ENABLE, 32'h8100_0000);
		for (int i = 0; i < 230 && irq !== 1'b1; i++) @(posedge pclk);
		chk("timer irq", 32'h1, 32'(irq));
		rd(OFS_DATA0, 32'hE, "timer latch");
		wr(OFS_CLOCK_CLEAR, 32'h0);
		rd(OFS_CLOCK_CLEAR, 32'h0, "clear read");
		$display("test latches done");
		wr(OFS_INT_ENABLE, 32'h8000_0100);
		enc(3'h4, 2'h0, 8'h01);
		chk("index irq", 32'h1, 32'(irq));
		rd(OFS_INT_STATUS, 32'h100, "status");
		rd(OFS_CLOCK_CLEAR, 32'h0, "clear read");
		repeat (3) @(posedge pclk);
		chk("irq cleared", 32'h0, 32'(irq));
		wr(OFS_INT_ENABLE, 32'h8000_0000);
		enc(3'h4, 2'h0, 8'h01);
		chk("masked irq", 32'h0, 32'(irq));
		$display("test interrupts done");
		wr(OFS_MODE0 + 8'h08, 32'h15);
		rst_ch(2'h2);
		enc(3'h2, 2'h2, 8'h01, 8'h01);
		wr(OFS_SOFT_CAPTURE, 32'h4);
		rd(OFS_DATA0 + 8'h08, 32'h0, "glitch fast");
		wr(OFS_CLOCK_CLEAR, 32'h3);
		enc(3'h2, 2'h2, 8'h01, 8'h13);
		enc(3'h2, 2'h2, 8'h01, 8'h3B);
		wr(OFS_SOFT_CAPTURE, 32'h4);
		rd(OFS_DATA0 + 8'h08, 32'h1, "slow filter");
		$display("test filter done");
		stop_test();
	end
endmodule : tb_quad_encoder_counter_channel
`default_nettype wire
